/* File: eic_pkg.sv */
// eic_pkg: offsets, field positions, reset values for the external irq pair
// assumes: one 8-bit register port; control and peripheral flags byte-wide, polarity, status and mask 2 bits
package eic_pkg;
  // ----------------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------------
  localparam logic [3:0] CTRL_OFS = 4'h0;
  localparam logic [3:0] POLARITY_OFS = 4'h1;
  localparam logic [3:0] STATUS_OFS = 4'h2;
  localparam logic [3:0] MASK_OFS = 4'h3;
  localparam logic [3:0] PERIPH_FIRST_OFS = 4'h4;
  localparam logic [3:0] PERIPH_SECOND_OFS = 4'h5;
  // ----------------------------------------------------------------------
  // control register fields
  // ----------------------------------------------------------------------
  localparam int PIN_TWO_PRIORITY_BIT = 7;
  localparam int PIN_ONE_PRIORITY_BIT = 6;
  localparam int PIN_TWO_ENABLE_BIT = 4;
  localparam int PIN_ONE_ENABLE_BIT = 3;
  localparam int PIN_TWO_FLAG_BIT = 1;
  localparam int PIN_ONE_FLAG_BIT = 0;
  localparam logic [7:0] CTRL_WMASK = 8'hdb;
  localparam logic [7:0] CTRL_RESET = 8'hc0;
  // ----------------------------------------------------------------------
  // polarity register fields
  // ----------------------------------------------------------------------
  localparam int PIN_ONE_POL_BIT = 0;
  localparam int PIN_TWO_POL_BIT = 1;
  localparam logic [1:0] POLARITY_RESET = 2'h0;
  // ----------------------------------------------------------------------
  // status register: bit 0 pin one edge, bit 1 pin two edge
  // ----------------------------------------------------------------------
  localparam int STATUS_W = 2;
  localparam logic [1:0] STATUS_RESET = 2'h0;
  localparam logic [1:0] MASK_RESET = 2'h0;
  localparam logic [7:0] PERIPH_RESET = 8'h00;
endpackage

/* File: eic_edge_detect.sv */
// eic_edge_detect: per-pin edge detector with polarity select
// assumes: pins already synchronous to clock
`timescale 1ns/1ps
`default_nettype none
module eic_edge_detect (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [1:0] pin,
  input wire logic [1:0] rising,
  output logic [1:0] edge_hit
);
  logic [1:0] prev_q;

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      prev_q <= 2'h0;
    end else begin
      prev_q <= pin;
    end
  end

  // ----------------------------------------------------------------------
  // edge select per pin
  // ----------------------------------------------------------------------
  for (genvar i = 0; i < 2; i++) begin : g_pin
    // first cycle after reset sees prev low, so a high pin gives a rise
    assign edge_hit[i] = rising[i] ? (pin[i] & ~prev_q[i])
                                   : (~pin[i] & prev_q[i]); // see (RQ9)
  end
endmodule
`default_nettype wire

/* File: eic_top.sv */
// eic_top: control, flags and interrupt output for two external irq pins
// assumes: synchronous pins, single clock, register port with 1-cycle read
//
// How it works
// (RQ1) control bit 7 holds pin two priority, 1 high, 0 low
// (RQ2) control bit 6 holds pin one priority, 1 high, 0 low
// (RQ3) control bit 4 enables pin two interrupt
// (RQ4) control bit 3 enables pin one interrupt
// (RQ5) flags at bits 1 and 0 set on event, cleared by writing zero
// (RQ6) flags set regardless of individual or global enable
// (RQ7) software should clear flags before enabling and after servicing
// (RQ8) peripheral flags live in two separate request flag registers
// (RQ9) per-pin polarity bit picks rising (1) or falling (0) edge
// (RQ10) bits 5 and 2 read zero, writes ignored; priorities reset to one
//
// Added by the designer: the register offsets and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module eic_top (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic ext_irq_pin_one,
  input wire logic ext_irq_pin_two,
  input wire logic global_irq_enable,
  input wire logic [7:0] periph_set_first,
  input wire logic [7:0] periph_set_second,
  input wire logic [3:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [7:0] rdata,
  output logic pin_one_request,
  output logic pin_two_request,
  output logic pin_one_high_prio,
  output logic pin_two_high_prio,
  output logic irq
);
  logic [7:0] ctrl_q;
  logic [1:0] polarity_q;
  logic [1:0] status_q;
  logic [1:0] mask_q;
  logic [7:0] periph_flags_first_q;
  logic [7:0] periph_flags_second_q;
  logic [1:0] edge_hit;
  logic [7:0] rdata_q;
  logic pin_one_request_q;
  logic pin_two_request_q;
  logic irq_q;
  logic ctrl_wr;
  logic [7:0] ctrl_d;
  logic [7:0] rmux;

  assign ctrl_wr = wr_en && (addr == eic_pkg::CTRL_OFS);

  // ----------------------------------------------------------------------
  // edge detection
  // ----------------------------------------------------------------------
  eic_edge_detect u_edge (
    .clock(clock),
    .rst_n(rst_n),
    .pin({ext_irq_pin_two, ext_irq_pin_one}),
    .rising({polarity_q[eic_pkg::PIN_TWO_POL_BIT],
             polarity_q[eic_pkg::PIN_ONE_POL_BIT]}),
    .edge_hit(edge_hit)
  );

  // ----------------------------------------------------------------------
  // control register
  // ----------------------------------------------------------------------
  always_comb begin
    ctrl_d = ctrl_q;
    if (ctrl_wr) begin
      // unimplemented bits stay zero through the write mask
      ctrl_d = wdata & eic_pkg::CTRL_WMASK; // see (RQ10)
      // a one written to a flag cannot set it; software only clears
      ctrl_d[eic_pkg::PIN_ONE_FLAG_BIT] =
        wdata[eic_pkg::PIN_ONE_FLAG_BIT] &
        ctrl_q[eic_pkg::PIN_ONE_FLAG_BIT]; // see (RQ5)
      ctrl_d[eic_pkg::PIN_TWO_FLAG_BIT] =
        wdata[eic_pkg::PIN_TWO_FLAG_BIT] &
        ctrl_q[eic_pkg::PIN_TWO_FLAG_BIT]; // see (RQ5)
    end
    // event wins over a same-cycle clear; enables are not consulted
    if (edge_hit[0]) begin
      ctrl_d[eic_pkg::PIN_ONE_FLAG_BIT] = 1'b1; // see (RQ6)
    end
    if (edge_hit[1]) begin
      ctrl_d[eic_pkg::PIN_TWO_FLAG_BIT] = 1'b1; // see (RQ6)
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      ctrl_q <= eic_pkg::CTRL_RESET; // see (RQ10)
    end else begin
      ctrl_q <= ctrl_d; // see (RQ1) (RQ2) (RQ3) (RQ4)
    end
  end

  // ----------------------------------------------------------------------
  // polarity register
  // ----------------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      polarity_q <= eic_pkg::POLARITY_RESET;
    end else if (wr_en && addr == eic_pkg::POLARITY_OFS) begin
      polarity_q <= wdata[1:0]; // see (RQ9)
    end
  end

  // ----------------------------------------------------------------------
  // sticky status, write one to clear, set wins
  // ----------------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      status_q <= eic_pkg::STATUS_RESET;
    end else if (wr_en && addr == eic_pkg::STATUS_OFS) begin
      status_q <= (status_q & ~wdata[1:0]) | edge_hit;
    end else begin
      status_q <= status_q | edge_hit;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      mask_q <= eic_pkg::MASK_RESET;
    end else if (wr_en && addr == eic_pkg::MASK_OFS) begin
      mask_q <= wdata[1:0];
    end
  end

  // ----------------------------------------------------------------------
  // peripheral request flag registers, set by sources, cleared by zero
  // ----------------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      periph_flags_first_q <= eic_pkg::PERIPH_RESET;
    end else if (wr_en && addr == eic_pkg::PERIPH_FIRST_OFS) begin
      periph_flags_first_q <= (periph_flags_first_q & wdata) |
                              periph_set_first; // see (RQ8)
    end else begin
      periph_flags_first_q <= periph_flags_first_q | periph_set_first;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      periph_flags_second_q <= eic_pkg::PERIPH_RESET;
    end else if (wr_en && addr == eic_pkg::PERIPH_SECOND_OFS) begin
      periph_flags_second_q <= (periph_flags_second_q & wdata) |
                               periph_set_second; // see (RQ8)
    end else begin
      periph_flags_second_q <= periph_flags_second_q | periph_set_second;
    end
  end

  // ----------------------------------------------------------------------
  // read port, data in the cycle after the strobe
  // ----------------------------------------------------------------------
  always_comb begin
    unique case (addr)
      eic_pkg::CTRL_OFS: rmux = ctrl_q;
      eic_pkg::POLARITY_OFS: rmux = {6'h00, polarity_q};
      eic_pkg::STATUS_OFS: rmux = {6'h00, status_q};
      eic_pkg::MASK_OFS: rmux = {6'h00, mask_q};
      eic_pkg::PERIPH_FIRST_OFS: rmux = periph_flags_first_q;
      eic_pkg::PERIPH_SECOND_OFS: rmux = periph_flags_second_q;
      default: rmux = 8'h00;
    endcase
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      rdata_q <= 8'h00;
    end else if (rd_en) begin
      rdata_q <= rmux;
    end else begin
      rdata_q <= 8'h00;
    end
  end

  // ----------------------------------------------------------------------
  // requests and interrupt output
  // ----------------------------------------------------------------------
  // requests gated by enable and global enable; the flag alone never asks
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      pin_one_request_q <= 1'b0;
      pin_two_request_q <= 1'b0;
    end else begin
      pin_one_request_q <= global_irq_enable &
        ctrl_d[eic_pkg::PIN_ONE_ENABLE_BIT] &
        ctrl_d[eic_pkg::PIN_ONE_FLAG_BIT]; // see (RQ4)
      pin_two_request_q <= global_irq_enable &
        ctrl_d[eic_pkg::PIN_TWO_ENABLE_BIT] &
        ctrl_d[eic_pkg::PIN_TWO_FLAG_BIT]; // see (RQ3)
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(status_q & mask_q);
    end
  end

  assign rdata = rdata_q;
  assign pin_one_request = pin_one_request_q;
  assign pin_two_request = pin_two_request_q;
  assign pin_one_high_prio = ctrl_q[eic_pkg::PIN_ONE_PRIORITY_BIT]; // see (RQ2)
  assign pin_two_high_prio = ctrl_q[eic_pkg::PIN_TWO_PRIORITY_BIT]; // see (RQ1)
  assign irq = irq_q;
endmodule
`default_nettype wire

/* File: eic_top_sva.sv */
// eic_top_sva: port-level checks bound into eic_top
// assumes: one clock, synchronous active-low reset
`timescale 1ns/1ps
`default_nettype none
module eic_chk (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic global_irq_enable,
  input wire logic [3:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [7:0] rdata,
  input wire logic pin_one_request,
  input wire logic pin_two_request,
  input wire logic pin_one_high_prio,
  input wire logic pin_two_high_prio,
  input wire logic irq
);
  // ----------
  // assertions
  // ----------
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  wire cw = wr_en && addr == 4'h0;
  wire cr = rd_en && addr == 4'h0;
  wire iw = wr_en && addr[3:1] == 3'h1;
  property p_pr2; cw |=> pin_two_high_prio == $past(wdata[7]); endproperty
  a_pr2: assert property (p_pr2) else $error("prio two");
  property p_pr1; cw |=> pin_one_high_prio == $past(wdata[6]); endproperty
  a_pr1: assert property (p_pr1) else $error("prio one");
  property p_gap; cr |=> rdata[5] == 1'b0 && rdata[2] == 1'b0; endproperty
  a_gap: assert property (p_gap) else $error("unused bits");
  property p_map; rd_en && addr > 4'h5 |=> rdata == 8'h00; endproperty
  a_map: assert property (p_map) else $error("unmapped");
  property p_g2; pin_two_request |-> $past(global_irq_enable); endproperty
  a_g2: assert property (p_g2) else $error("gate two");
  property p_g1; pin_one_request |-> $past(global_irq_enable); endproperty
  a_g1: assert property (p_g1) else $error("gate one");
  // writes one cycle back are excluded too: outputs are registered
  property p_hold; pin_one_request && global_irq_enable && !cw && !$past(cw)
    |=> pin_one_request; endproperty
  a_hold: assert property (p_hold) else $error("flag lost");
  property p_irq; irq && !iw && !$past(iw) |=> irq; endproperty
  a_irq: assert property (p_irq) else $error("irq lost");
  c_req: cover property (pin_one_request && pin_two_request);
  c_irq: cover property ($rose(irq));
  c_low: cover property (cw && wdata[7:6] == 2'h0);
endmodule
bind eic_top eic_chk u_chk (.*);
`default_nettype wire

/* File: eic_pins.sv */
// eic_pins: board-side model of the two external irq pins
// assumes: bench sets wanted levels, pins follow at the next rising edge
`timescale 1ns/1ps
`default_nettype none
module eic_pins (
  input wire logic clock,
  input wire logic [1:0] level,
  output logic ext_irq_pin_one,
  output logic ext_irq_pin_two
);
  // registered so a pin never moves on the edge that samples it
  always_ff @(posedge clock)
    {ext_irq_pin_two, ext_irq_pin_one} <= level;
endmodule
`default_nettype wire

/* File: testbench.sv */
// testbench: directed register and pin tests for eic_top
// assumes: eic_pins drives the pins, bench is the register master
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clock, rst_n, global_irq_enable, wr_en, rd_en, p1, p2, irq;
  logic rq1, rq2, hp1, hp2;
  logic [7:0] periph_set_first, periph_set_second, wdata, rdata;
  logic [3:0] addr;
  logic [1:0] level;
  wire [7:0] outs = {3'h0, irq, rq2, rq1, hp2, hp1};
  int n_errors = 0;
  int total_checks = 0;
  eic_pins pins (.clock, .level, .ext_irq_pin_one(p1),
    .ext_irq_pin_two(p2));
  eic_top uut (.clock, .rst_n, .ext_irq_pin_one(p1), .ext_irq_pin_two(p2),
    .global_irq_enable, .periph_set_first, .periph_set_second, .addr,
    .wdata, .wr_en, .rd_en, .rdata, .pin_one_request(rq1),
    .pin_two_request(rq2), .pin_one_high_prio(hp1),
    .pin_two_high_prio(hp2), .irq);
  // -----
  // tasks
  // -----
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clock);
    {wr_en, addr, wdata} <= {1'b1, a, d};
    @(posedge clock);
    wr_en <= 1'b0;
  endtask
  // sample just past the edge so the registered answer has landed
  task automatic rd(input logic [3:0] a, input logic [7:0] e,
    input logic [7:0] o);
    @(posedge clock);
    {rd_en, addr} <= {1'b1, a};
    @(posedge clock);
    rd_en <= 1'b0;
    #1 chk(rdata, e);
    chk(outs, o);
  endtask
  task automatic print_verdict();
    $display("errors %0d checks %0d", n_errors, total_checks);
    if (n_errors == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  initial begin
    #20000;
    n_errors++;
    print_verdict();
  end
  initial begin
    {rst_n, global_irq_enable, wr_en, rd_en, addr, wdata, level} = '0;
    {periph_set_first, periph_set_second} = '0;
    repeat (10) @(posedge clock);
    rst_n <= 1'b1;
    rd(4'h0, 8'hc0, 8'h03);
    wr(4'h0, 8'hff);
    rd(4'h0, 8'hd8, 8'h03);
    wr(4'h0, 8'h00);
    rd(4'h0, 8'h00, 8'h00);
    wr(4'h3, 8'h03);
    level <= 2'h1;
    repeat (3) @(posedge clock);
    level <= 2'h0;
    repeat (3) @(posedge clock);
    rd(4'h0, 8'h01, 8'h10);
    wr(4'h2, 8'h01);
    wr(4'h0, 8'h00);
    rd(4'h2, 8'h00, 8'h00);
    rd(4'h0, 8'h00, 8'h00);
    wr(4'h1, 8'h03);
    global_irq_enable <= 1'b1;
    wr(4'h0, 8'h18);
    level <= 2'h3;
    repeat (3) @(posedge clock);
    rd(4'h0, 8'h1b, 8'h1c);
    wr(4'h3, 8'h00);
    wr(4'h0, 8'h0b);
    level <= 2'h0;
    repeat (3) @(posedge clock);
    rd(4'h0, 8'h0b, 8'h04);
    {periph_set_first, periph_set_second} <= 16'h4180;
    @(posedge clock);
    {periph_set_first, periph_set_second} <= 16'h0000;
    rd(4'h4, 8'h41, 8'h04);
    rd(4'h5, 8'h80, 8'h04);
    wr(4'h4, 8'h00);
    rd(4'h4, 8'h00, 8'h04);
    rd(4'hf, 8'h00, 8'h04);
    print_verdict();
  end
endmodule
`default_nettype wire
